// ---- logic/mps_consts.svh ----
// Constants for the microprogram control sequencer
//
// Summary of operation
// [R1] Instruction register loads from the d_selector only when the microword commands it.
// [R2] Combinational instruction_decode of the IR feeds branch codes, condition and ALU logic.
// [R3] Combinational condition logic updates N, Z, V, C late in the instruction.
// [R4] Decode outputs plus status_select_code choose the condition-code data inputs.
// [R5] status_select_code also selects a whole status load from the d_selector.
// [R6] data_alteration_code merges with alu_function_field to alter the ALU operation.
// [R7] In shared late phases data_alteration_code combines with IR to pick the ALU operation.
// [R8] Wait and halt flag flip-flops feed the branch logic directly.
// [R9] IR decoding is encoded into basic_branch_code values of two to five bits.
// [R10] Alteration output is five bits; low bits have more sources than high bits.
// [R11] The instruction_branch_class one to three codes are up to five bits wide.
// [R12] Two-way branches use one IR bit; flag inputs alter only one bit.
// [R13] Five-bit branch_select_field picks the alteration source, up to 37 octal codes.
// [R14] Control store holds 256 microwords, each one machine state.
// [R15] Control store output is wired-OR with an expansion store input.
// [R16] Microword register captures the store output at each machine state start.
// [R17] Control bits select sources and enable gate pulses at state end.
// [R18] Microword register clocks on the last edge of the selected-length machine cycle.
// [R19] Bits 8..0 form the next address, bits 56..9 the control field.
// [R20] The fetch address is the held pointer, with no alteration applied yet.
// [R21] A branch test alters the word after next; the next word is unconditional.
// [R22] Alterations are ORed into the next-address field and clocked at state end.
// [R23] Reset loads a fixed start microaddress and a cleared microword.
// [R24] With no alteration selected the selector output is all zeros.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

// ****************************************************************
// Microword layout
// ****************************************************************
`define MPS_UW_W 57
`define MPS_NXT_W 9
`define MPS_BSEL_LSB 9
`define MPS_CLEN_LSB 14
`define MPS_ALUF_LSB 16
`define MPS_ALUM_BIT 20
`define MPS_DAC_LSB 21
`define MPS_SSC_LSB 24
`define MPS_LDIR_BIT 28
`define MPS_SETW_BIT 29
`define MPS_SETH_BIT 30
`define MPS_CLRF_BIT 31
`define MPS_DSEL_LSB 32
`define MPS_GATE_LSB 34

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define MPS_REG_CTRL 8'h00
`define MPS_REG_STATUS 8'h04
`define MPS_REG_IR 8'h08
`define MPS_REG_SADDR 8'h0c
`define MPS_REG_SLO 8'h10
`define MPS_REG_SHI 8'h14
`define MPS_CTRL_RST 1'b1
`define MPS_START_ADDR 9'h000

// ****************************************************************
// Machine cycle lengths
// ****************************************************************
`define MPS_CLK_MHZ 250
`define MPS_CYC_SHORT_NS 140
`define MPS_CYC_MID_NS 200
`define MPS_CYC_LONG_NS 300
`define MPS_CYC_SHORT ((`MPS_CYC_SHORT_NS * `MPS_CLK_MHZ + 999) / 1000)
`define MPS_CYC_MID ((`MPS_CYC_MID_NS * `MPS_CLK_MHZ + 999) / 1000)
`define MPS_CYC_LONG ((`MPS_CYC_LONG_NS * `MPS_CLK_MHZ + 999) / 1000)

`endif

// ---- logic/mps_pkg.sv ----
// Types shared by the microprogram control sequencer
package mps_pkg;
    typedef logic [56:0] mps_uword_t;
    // Branch test codes held in branch_select_field
    typedef enum logic [4:0] {
        BS_NONE = 5'h00, BS_CLASS1 = 5'h01, BS_CLASS2 = 5'h02, BS_CLASS3 = 5'h03,
        BS_NARROW = 5'h04, BS_IR_BYTE = 5'h05, BS_IR_SRC0 = 5'h06, BS_IR_DST0 = 5'h07,
        BS_IR_BIT0 = 5'h08, BS_WAIT = 5'h09, BS_HALT = 5'h0a, BS_CC_Z = 5'h0b,
        BS_CC_N = 5'h0c, BS_CC_C = 5'h0d, BS_CC_V = 5'h0e, BS_FOUR_WAY = 5'h0f,
        BS_DST_MODE = 5'h10
    } mps_bsel_t;
    // Status select codes
    typedef enum logic [3:0] {
        SS_HOLD = 4'h0, SS_LOAD_ALL = 4'h1, SS_MOVE = 4'h2, SS_ARITH = 4'h3,
        SS_OVF = 4'h4, SS_SHIFT = 4'h5
    } mps_ssc_t;
endpackage : mps_pkg

// ---- logic/mps_branch_sel.sv ----
// Branch alteration selector for the next-address OR logic
`timescale 1ns/1ps
module mps_branch_sel (
    // Test select
    input wire logic [4:0] branchSelect,
    // Alteration sources
    input wire logic [4:0] bbcClass1,
    input wire logic [4:0] bbcClass2,
    input wire logic [4:0] bbcClass3,
    input wire logic [3:0] irBits,
    input wire logic waitFlag,
    input wire logic haltFlag,
    input wire logic [3:0] ccBits,
    // Alteration out
    output logic [4:0] alter
);
    // Narrow sources land on bit 0, so low bits see many more inputs
    always_comb begin
        case (mps_pkg::mps_bsel_t'(branchSelect)) // [R13] [R10]
            mps_pkg::BS_CLASS1: alter = bbcClass1; // [R11]
            mps_pkg::BS_CLASS2: alter = bbcClass2; // [R11]
            mps_pkg::BS_CLASS3: alter = bbcClass3; // [R11]
            mps_pkg::BS_NARROW: alter = {2'b00, bbcClass2[2:0]}; // [R9]
            mps_pkg::BS_IR_BYTE: alter = {4'h0, irBits[3]}; // [R12]
            mps_pkg::BS_IR_SRC0: alter = {4'h0, irBits[2]}; // [R12]
            mps_pkg::BS_IR_DST0: alter = {4'h0, irBits[1]}; // [R12]
            mps_pkg::BS_IR_BIT0: alter = {4'h0, irBits[0]}; // [R12]
            mps_pkg::BS_WAIT: alter = {4'h0, waitFlag}; // [R8] [R12]
            mps_pkg::BS_HALT: alter = {4'h0, haltFlag}; // [R8] [R12]
            mps_pkg::BS_CC_Z: alter = {4'h0, ccBits[2]};
            mps_pkg::BS_CC_N: alter = {4'h0, ccBits[3]};
            mps_pkg::BS_CC_C: alter = {4'h0, ccBits[0]};
            mps_pkg::BS_CC_V: alter = {4'h0, ccBits[1]};
            mps_pkg::BS_FOUR_WAY: alter = {3'h0, irBits[3], irBits[2]}; // [R9]
            mps_pkg::BS_DST_MODE: alter = {1'b0, bbcClass2[4:2], 1'b0}; // [R9]
            default: alter = 5'h00; // [R24]
        endcase
    end
endmodule : mps_branch_sel

// ---- logic/mps_cond_codes.sv ----
// Condition-code update logic for the status register
`timescale 1ns/1ps
module mps_cond_codes (
    // Selection
    input wire logic [3:0] statusSelect,
    input wire logic isByte,
    // Computed conditions
    input wire logic [15:0] dVal,
    input wire logic aluCout,
    input wire logic aluOvf,
    input wire logic [3:0] ccNow,
    // Results
    output logic [3:0] ccNext,
    output logic ccLoad,
    output logic psLoadAll
);
    logic negBit;
    logic zeroBit;

    // Byte operations judge sign and zero on the low byte only
    assign negBit = isByte ? dVal[7] : dVal[15]; // [R4]
    assign zeroBit = isByte ? (dVal[7:0] == 8'h00) : (dVal == 16'h0000); // [R3] [R4]

    // N Z V C order, high to low
    always_comb begin
        ccNext = ccNow;
        ccLoad = 1'b1;
        psLoadAll = 1'b0;
        case (mps_pkg::mps_ssc_t'(statusSelect)) // [R3] [R4]
            mps_pkg::SS_LOAD_ALL: begin
                ccLoad = 1'b0;
                psLoadAll = 1'b1; // [R5]
            end
            mps_pkg::SS_MOVE: ccNext = {negBit, zeroBit, 1'b0, ccNow[0]};
            mps_pkg::SS_ARITH: ccNext = {negBit, zeroBit, aluOvf, aluCout};
            mps_pkg::SS_OVF: ccNext = {negBit, zeroBit, aluOvf, ccNow[0]};
            mps_pkg::SS_SHIFT: ccNext = {negBit, zeroBit, negBit ^ aluCout, aluCout};
            default: ccLoad = 1'b0;
        endcase
    end
endmodule : mps_cond_codes

// ---- logic/mps_sequencer.sv ----
// Microprogram control sequencer top with control store and register slave
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_sequencer #(
    parameter int DEPTH = 256,
    parameter logic [8:0] START_ADDR = `MPS_START_ADDR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Data path inputs
    input wire logic [15:0] busData,
    input wire logic [15:0] readData,
    input wire logic [15:0] dRegIn,
    input wire logic aluCout,
    input wire logic aluOvf,
    // Expansion store, wired-OR onto the store output
    input wire logic [56:0] expWord,
    // Control outputs
    output logic [47:0] ctrlField,
    output logic [8:0] nextMicroPointer,
    output logic [15:0] irOut,
    output logic [7:0] pswOut,
    output logic [15:0] dSelOut,
    output logic [3:0] aluOp,
    output logic aluMode,
    output logic aluCarryIn,
    output logic [1:0] gatePulse,
    output logic waitFlag,
    output logic haltFlag,
    output logic stateEnd
);
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (DEPTH != 256) begin : gDepthChk
        $error("control store depth must be 256");
    end

    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [56:0] store [DEPTH];
    mps_pkg::mps_uword_t uwordQ;
    logic [8:0] uppQ;
    logic [6:0] cycCntQ;
    logic [15:0] irQ;
    logic [7:0] pswQ;
    logic waitQ;
    logic haltQ;
    logic runQ;
    logic [7:0] sAddrQ;
    logic [31:0] sLoQ;
    logic wrPendQ;
    logic [7:0] busAddrQ;
    logic [31:0] rdataQ;

    // Microword field views
    logic [4:0] branchSelect;
    logic [1:0] cycLenCode;
    logic [3:0] aluField;
    logic [2:0] dataAltCode;
    logic [3:0] statusSelect;
    logic [1:0] dSelCode;
    assign branchSelect = uwordQ[`MPS_BSEL_LSB +: 5];
    assign cycLenCode = uwordQ[`MPS_CLEN_LSB +: 2];
    assign aluField = uwordQ[`MPS_ALUF_LSB +: 4];
    assign dataAltCode = uwordQ[`MPS_DAC_LSB +: 3];
    assign statusSelect = uwordQ[`MPS_SSC_LSB +: 4];
    assign dSelCode = uwordQ[`MPS_DSEL_LSB +: 2];

    // ****************************************************************
    // Machine cycle timing
    // ****************************************************************
    logic [6:0] cycLen;
    assign cycLen = (cycLenCode == 2'd0) ? 7'(`MPS_CYC_SHORT) :
                    (cycLenCode == 2'd1) ? 7'(`MPS_CYC_MID) : 7'(`MPS_CYC_LONG); // [R18]
    // The last cycle of the count is the final edge of the machine state
    assign stateEnd = runQ && (cycCntQ == cycLen - 7'd1); // [R18]

    // Cycle counter; halts in place while software stops the machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cycCntQ <= 7'h00;
        end else if (stateEnd) begin
            cycCntQ <= 7'h00;
        end else if (runQ) begin
            cycCntQ <= cycCntQ + 7'd1;
        end
    end

    // ****************************************************************
    // Control store fetch and address loop
    // ****************************************************************
    logic [56:0] storeWord;
    logic [56:0] fetchWord;
    logic [4:0] alter;
    logic [8:0] uppD;
    // Fetch uses the held pointer; no alteration reaches it this state
    assign storeWord = uppQ[8] ? 57'h0 : store[uppQ[7:0]]; // [R20] [R14]
    assign fetchWord = storeWord | expWord; // [R15]
    // Altered bits of the base field are zero, so OR acts as the branch
    assign uppD = fetchWord[8:0] | {4'h0, alter}; // [R19] [R22]
    assign nextMicroPointer = uppQ;
    assign ctrlField = uwordQ[56:9]; // [R19]

    // Word fetched now runs next state; its field takes this state's test
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uwordQ <= '0; // [R23]
            uppQ <= START_ADDR; // [R23]
        end else if (stateEnd) begin
            uwordQ <= fetchWord; // [R16] [R21]
            uppQ <= uppD; // [R22]
        end
    end

    // ****************************************************************
    // Instruction register and decode
    // ****************************************************************
    logic [15:0] dSel;
    logic isByte;
    logic srcZero;
    logic dstZero;
    logic [4:0] bbcClass1;
    logic [4:0] bbcClass2;
    logic [4:0] bbcClass3;
    always_comb begin
        case (dSelCode)
            2'd0: dSel = busData;
            2'd1: dSel = readData;
            2'd2: dSel = dRegIn;
            default: dSel = {1'b0, dRegIn[15:1]};
        endcase
    end
    assign dSelOut = dSel;
    // Decode is purely combinational from the held instruction
    assign isByte = irQ[15]; // [R2]
    assign srcZero = irQ[11:9] == 3'h0; // [R2]
    assign dstZero = irQ[5:3] == 3'h0; // [R2]
    assign bbcClass1 = {irQ[14:12], isByte, srcZero}; // [R9] [R11]
    assign bbcClass2 = {irQ[5:3], isByte, srcZero}; // [R9] [R11]
    assign bbcClass3 = {irQ[15:12], dstZero}; // [R9] [R11]
    assign irOut = irQ;

    // Instruction register captures only on the commanded state end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irQ <= 16'h0000;
        end else if (stateEnd && uwordQ[`MPS_LDIR_BIT]) begin
            irQ <= dSel; // [R1]
        end
    end

    // ****************************************************************
    // Status register and condition codes
    // ****************************************************************
    logic [3:0] ccNext;
    logic ccLoad;
    logic psLoadAll;
    mps_cond_codes uCond (
        .statusSelect(statusSelect),
        .isByte(isByte),
        .dVal(dSel),
        .aluCout(aluCout),
        .aluOvf(aluOvf),
        .ccNow(pswQ[3:0]),
        .ccNext(ccNext),
        .ccLoad(ccLoad),
        .psLoadAll(psLoadAll)
    );
    assign pswOut = pswQ;

    // Condition codes change at the end of the state that selects them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pswQ <= 8'h00;
        end else if (stateEnd && psLoadAll) begin
            pswQ <= dSel[7:0]; // [R5]
        end else if (stateEnd && ccLoad) begin
            pswQ[3:0] <= ccNext; // [R3] [R4]
        end
    end

    // ****************************************************************
    // ALU control
    // ****************************************************************
    always_comb begin
        aluOp = aluField;
        aluCarryIn = 1'b0;
        case (dataAltCode)
            3'd1: aluCarryIn = 1'b1; // [R6]
            3'd2: aluOp = aluField ^ 4'h1; // [R6]
            3'd3: aluOp = aluField | {1'b0, irQ[14:12]}; // [R7]
            3'd4: aluCarryIn = pswQ[0]; // [R6]
            3'd5: aluOp = irQ[15:12]; // [R7]
            default: aluOp = aluField; // [R6]
        endcase
    end
    assign aluMode = uwordQ[`MPS_ALUM_BIT];
    // Gate pulses only fire on the closing edge of the state
    assign gatePulse = stateEnd ? uwordQ[`MPS_GATE_LSB +: 2] : 2'b00; // [R17]

    // ****************************************************************
    // Flags and branch selection
    // ****************************************************************
    // Set wins over clear so a flag raised in the clearing state is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitQ <= 1'b0;
            haltQ <= 1'b0;
        end else if (stateEnd) begin
            waitQ <= uwordQ[`MPS_SETW_BIT] | (waitQ & ~uwordQ[`MPS_CLRF_BIT]); // [R8]
            haltQ <= uwordQ[`MPS_SETH_BIT] | (haltQ & ~uwordQ[`MPS_CLRF_BIT]); // [R8]
        end
    end
    assign waitFlag = waitQ;
    assign haltFlag = haltQ;

    mps_branch_sel uBranch (
        .branchSelect(branchSelect),
        .bbcClass1(bbcClass1),
        .bbcClass2(bbcClass2),
        .bbcClass3(bbcClass3),
        .irBits({isByte, srcZero, dstZero, irQ[0]}),
        .waitFlag(waitQ),
        .haltFlag(haltQ),
        .ccBits(pswQ[3:0]),
        .alter(alter)
    );

    // ****************************************************************
    // AHB-Lite register slave
    // ****************************************************************
    logic addrPhase;
    logic wrCommit;
    logic [31:0] rdMux;
    logic [56:0] sRead;
    // Zero wait states: every transfer completes in its data phase, OKAY
    assign addrPhase = hsel && hready && htrans[1];
    assign wrCommit = wrPendQ;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdataQ;
    assign sRead = store[sAddrQ];
    always_comb begin
        case (haddr[7:0])
            `MPS_REG_CTRL: rdMux = {31'h0, runQ};
            `MPS_REG_STATUS: rdMux = {13'h0, haltQ, waitQ, pswQ, uppQ};
            `MPS_REG_IR: rdMux = {16'h0, irQ};
            `MPS_REG_SADDR: rdMux = {24'h0, sAddrQ};
            `MPS_REG_SLO: rdMux = sRead[31:0];
            `MPS_REG_SHI: rdMux = {7'h0, sRead[56:32]};
            default: rdMux = 32'h0;
        endcase
    end

    // Address phase capture; read data is taken here so it leaves a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPendQ <= 1'b0;
            busAddrQ <= 8'h00;
            rdataQ <= 32'h0;
        end else begin
            wrPendQ <= addrPhase && hwrite;
            busAddrQ <= haddr[7:0];
            if (addrPhase && !hwrite) begin
                rdataQ <= rdMux;
            end
        end
    end

    // Writes land in the data phase; the high half commits a store word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runQ <= `MPS_CTRL_RST;
            sAddrQ <= 8'h00;
            sLoQ <= 32'h0;
        end else if (wrCommit) begin
            case (busAddrQ)
                `MPS_REG_CTRL: runQ <= hwdata[0];
                `MPS_REG_SADDR: sAddrQ <= hwdata[7:0];
                `MPS_REG_SLO: sLoQ <= hwdata;
                `MPS_REG_SHI: sAddrQ <= sAddrQ + 8'd1;
                default: sAddrQ <= sAddrQ;
            endcase
        end
    end

    // Store image write; array without reset, loaded by software
    always_ff @(posedge clk) begin
        if (wrCommit && busAddrQ == `MPS_REG_SHI) begin
            store[sAddrQ] <= {hwdata[24:0], sLoQ};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_IR_LOAD: assert property (@(posedge clk) disable iff (rst) // [R1]
        stateEnd && uwordQ[`MPS_LDIR_BIT] |=> irQ == $past(dSel))
        else $error("instruction register missed its load");
    AST_IR_HOLD: assert property (@(posedge clk) disable iff (rst) // [R1]
        !(stateEnd && uwordQ[`MPS_LDIR_BIT]) |=> $stable(irQ))
        else $error("instruction register changed without load");
    AST_UPP_OR: assert property (@(posedge clk) disable iff (rst) // [R22]
        stateEnd |=> uppQ == ($past(fetchWord[8:0]) | {4'h0, $past(alter)}))
        else $error("pointer not field ORed with alteration");
    AST_UWORD_LOAD: assert property (@(posedge clk) disable iff (rst) // [R16]
        stateEnd |=> uwordQ == $past(fetchWord))
        else $error("microword register missed store output");
    AST_STATE_HOLD: assert property (@(posedge clk) disable iff (rst) // [R18]
        !stateEnd |=> $stable(uppQ) && $stable(uwordQ))
        else $error("address loop moved inside a state");
    AST_SHORT_CYCLE: assert property (@(posedge clk) disable iff (rst) // [R18]
        stateEnd && runQ && fetchWord[`MPS_CLEN_LSB +: 2] == 2'd0 && !wrCommit
        |=> !stateEnd [*8])
        else $error("short machine state ended too early");
    AST_PS_LOAD: assert property (@(posedge clk) disable iff (rst) // [R5]
        stateEnd && statusSelect == 4'h1 |=> pswQ == $past(dSel[7:0]))
        else $error("status not loaded from d_selector");
    AST_NO_ALTER: assert property (@(posedge clk) disable iff (rst) // [R24]
        branchSelect == 5'h00 |-> alter == 5'h00)
        else $error("idle test produced an alteration");
    AST_FLAG_ONE_BIT: assert property (@(posedge clk) disable iff (rst) // [R12]
        branchSelect inside {5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a} |-> alter[4:1] == 4'h0)
        else $error("two-way test altered more than bit zero");
    AST_WAIT_BRANCH: assert property (@(posedge clk) disable iff (rst) // [R12]
        branchSelect == 5'h09 |-> alter == {4'h0, waitQ})
        else $error("wait test did not carry the wait flag");
    AST_WAIT_SET: assert property (@(posedge clk) disable iff (rst) // [R8]
        stateEnd && uwordQ[`MPS_SETW_BIT] |=> waitQ ##0 (branchSelect != 5'h09 || alter[0]))
        else $error("wait flag not set or not seen by branch");
    AST_ALU_PASS: assert property (@(posedge clk) disable iff (rst) // [R6]
        dataAltCode == 3'd0 |-> aluOp == aluField && !aluCarryIn)
        else $error("ALU field altered with no alteration code");
    AST_GATE_END: assert property (@(posedge clk) disable iff (rst) // [R17]
        gatePulse != 2'b00 |-> stateEnd)
        else $error("gate pulse outside state end");

    COV_BRANCH: cover property (@(posedge clk) disable iff (rst) stateEnd && alter != 5'h00);
    COV_PS_LOAD: cover property (@(posedge clk) disable iff (rst) stateEnd && psLoadAll);
    COV_IR_LOAD: cover property (@(posedge clk) disable iff (rst) stateEnd && uwordQ[`MPS_LDIR_BIT]);
    COV_STORE_WR: cover property (@(posedge clk) disable iff (rst) wrCommit && busAddrQ == `MPS_REG_SHI);
endmodule : mps_sequencer

// ---- test/mps_datapath_model.sv ----
// Behavioural model of the data path that feeds the sequencer
`timescale 1ns/1ps
module mps_datapath_model #(
    parameter logic [15:0] INSTR = 16'h1a2b
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data path values
    output logic [15:0] busData,
    output logic [15:0] readData,
    output logic [15:0] dRegIn,
    output logic aluCout,
    output logic aluOvf
);
    // Bus holds the fetched instruction; the other sources move each cycle so stale use shows up
    assign busData = INSTR;
    assign dRegIn = ~readData;
    assign aluCout = readData[0];
    assign aluOvf = readData[1];
    // Free running source counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readData <= 16'h0000;
        end else begin
            readData <= readData + 16'h0001;
        end
    end
endmodule : mps_datapath_model

// ---- test/tb.sv ----
// Self-checking testbench for the microprogram control sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH %0t got %h expected %h", $time, a, b); end end
module tb;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, aluCout, aluOvf;
    logic waitFlag, haltFlag, stateEnd, aluMode, aluCarryIn;
    logic [1:0] htrans = 2'h0, gatePulse;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] busData, readData, dRegIn, irOut, dSelOut;
    logic [47:0] ctrlField;
    logic [56:0] expWord = 57'h0;
    logic [8:0] nextMicroPointer;
    logic [7:0] pswOut;
    logic [3:0] aluOp;
    int error_cnt = 0, check_count = 0;
    // Reset-value rows: address beside the expected read data; the last row is unmapped
    logic [31:0] rowAddr [5] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h18};
    logic [31:0] rowExp [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    // Program: wait set, branch on wait in word 1, ALU alter and status load in word 2, IR load in word 5
    logic [56:0] prog [6] = '{57'h0_2000_0001, 57'h1202, 57'h0146_0004, 57'h0, 57'h0, 57'h1000_0005};
    logic [8:0] expPtr [4] = '{9'h001, 9'h002, 9'h005, 9'h005};

    mps_datapath_model u_mps_datapath_model (.clk(clk), .rst(rst), .busData(busData), .readData(readData),
        .dRegIn(dRegIn), .aluCout(aluCout), .aluOvf(aluOvf));
    // Expansion store word is driven by the bench so the wired-OR can be seen
    mps_sequencer u_mps_sequencer (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .busData(busData), .readData(readData), .dRegIn(dRegIn),
        .aluCout(aluCout), .aluOvf(aluOvf), .expWord(expWord), .ctrlField(ctrlField),
        .nextMicroPointer(nextMicroPointer), .irOut(irOut), .pswOut(pswOut), .dSelOut(dSelOut),
        .aluOp(aluOp), .aluMode(aluMode), .aluCarryIn(aluCarryIn), .gatePulse(gatePulse),
        .waitFlag(waitFlag), .haltFlag(haltFlag), .stateEnd(stateEnd));

    // ****************************************************************
    // Clock, bus tasks and verdict
    // ****************************************************************
    initial begin
        forever #2 clk = ~clk;
    end
    // Single AHB-Lite transfer; waits on hready in both phases rather than assuming zero waits
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        `CHK(hresp, 1'b0)
    endtask : ahb
    // Wait for the edge that closes a machine state, then let its updates land
    task wait_end;
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (stateEnd !== 1'b1 && n < 200);
        if (n >= 200) error_cnt++;
        @(posedge clk);
        #1;
    endtask : wait_end
    task test_done;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Watchdog; the whole run needs well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, rowAddr[i], 32'h0, rd);
            `CHK(rd, rowExp[i])
        end
        // Freeze the machine before the store holds anything defined
        ahb(1'b1, 32'h00, 32'h0, rd);
        ahb(1'b1, 32'h0c, 32'h0, rd);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, 32'h10, prog[i][31:0], rd);
            ahb(1'b1, 32'h14, {7'h00, prog[i][56:32]}, rd);
        end
        // Read back word 1 through the store window
        ahb(1'b1, 32'h0c, 32'h1, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        `CHK(rd, prog[1][31:0])
        `CHK(dSelOut, busData)
        ahb(1'b1, 32'h00, 32'h1, rd);
        for (int k = 0; k < 4; k++) begin
            wait_end();
            `CHK(nextMicroPointer, expPtr[k])
            if (k == 1) `CHK(waitFlag, 1'b1)
            if (k == 2) `CHK(ctrlField, prog[2][56:9])
            if (k == 2) `CHK(aluOp, 4'h7)
            if (k == 3) `CHK(pswOut, busData[7:0])
        end
        // The load command of word 5 only takes effect when its state closes
        wait_end();
        `CHK(irOut, busData)
        // Reset in mid-run returns the sequencer to its start state
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(nextMicroPointer, 9'h000)
        `CHK(ctrlField, 48'h0)
        `CHK(waitFlag, 1'b0)
        `CHK(haltFlag, 1'b0)
        `CHK(irOut, 16'h0)
        // Expansion word ORs a next-address bit into the first fetch after release
        @(posedge clk);
        rst <= 1'b0;
        expWord <= 57'h10;
        wait_end();
        `CHK(nextMicroPointer, 9'h011)
        test_done();
    end
endmodule : tb
